// *** core/icap_pkg.sv ***
// Shared constants and types for the six-unit input capture block
package icap_pkg;

  // Unit count and widths
  localparam int UNITS      = 6;
  localparam int PAIRS      = 3;
  localparam int CNT_W      = 16;
  localparam int SEL_W      = 5;
  localparam int SYNC_SRCS  = 30;
  localparam int CLK_SEL_W  = 3;
  localparam int EXT_CLKS   = 5;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W      = 2;
  localparam int IRQ_SEL_W  = 2;

  // Counter values
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;

  // Selector encodings
  localparam logic [SEL_W-1:0]     SYNC_NONE   = 5'h00;
  localparam logic [SEL_W-1:0]     SYNC_LAST   = 5'h1e;
  localparam logic [CLK_SEL_W-1:0] CLK_SYSTEM  = 3'h0;
  localparam logic [CLK_SEL_W-1:0] CLK_LAST    = 3'h5;
  localparam logic [IRQ_SEL_W-1:0] IRQ_CNT_ONE = 2'h1;
  localparam logic [IRQ_SEL_W-1:0] IRQ_CNT_0   = 2'h0;
  localparam logic [PTR_W-1:0]     PTR_ONE     = 2'h1;
  localparam logic [PTR_W:0]       LVL_ONE     = 3'h1;
  localparam logic [PTR_W:0]       LVL_FULL    = 3'h4;

  // Counter operating modes
  typedef enum logic [1:0] {
    ICAP_FREE,
    ICAP_SYNC,
    ICAP_HW_TRIG,
    ICAP_SW_TRIG
  } icap_mode_e;

endpackage

// *** core/icap_sync.sv ***
// Two-stage synchroniser for levels arriving from outside clk_sys
`timescale 1ns/1ps
`default_nettype none
module icap_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage_one;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule
`default_nettype wire

// *** core/icap_fifo.sv ***
// Four-entry capture store that refuses pushes when full
`timescale 1ns/1ps
`default_nettype none
module icap_fifo (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Fill side
  input  wire logic                       push,
  input  wire logic [icap_pkg::CNT_W-1:0] push_data,
  // Drain side
  input  wire logic                       pop,
  output logic      [icap_pkg::CNT_W-1:0] head,
  output logic                            empty,
  output logic                            full,
  output logic                            refused
);

  logic [icap_pkg::CNT_W-1:0] mem [icap_pkg::FIFO_DEPTH];
  logic [icap_pkg::PTR_W-1:0] wr_ptr;
  logic [icap_pkg::PTR_W-1:0] rd_ptr;
  logic [icap_pkg::PTR_W:0]   level;
  wire                        do_push;
  wire                        do_pop;

  // Status and accepted moves
  assign empty   = (level == '0);
  assign full    = (level == icap_pkg::LVL_FULL);
  // Empty store shows zero so the registered view never carries unknowns
  assign head    = empty ? '0 : mem[rd_ptr];
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  // Unread entries are never overwritten
  assign refused = push && full;

  // Storage is written only on accepted pushes
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + icap_pkg::PTR_ONE;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + icap_pkg::PTR_ONE;
      end
      if (do_push && !do_pop) begin
        level <= level + icap_pkg::LVL_ONE;
      end else if (do_pop && !do_push) begin
        level <= level - icap_pkg::LVL_ONE;
      end
    end
  end

endmodule
`default_nettype wire

// *** core/icap_top.sv ***
// Six input capture units with private counters, modes and cascading
//
// Notes on behaviour
// (RULE_01) Six capture units, each with its own settings and counter.
// (RULE_02) Units 2p and 2p+1 cascade to 32 bits in every mode.
// (RULE_03) Sync or trigger source chosen from thirty internal events.
// (RULE_04) Each unit holds captures in a four-entry first-in first-out store.
// (RULE_05) Private 16-bit counter clocked by one of six sources.
// (RULE_06) Free-running counter wraps from all ones to zero.
// (RULE_07) Counter advances only on ticks of its selected source.
// (RULE_08) A capture event pushes the counter's present value.
// (RULE_09) Synchronous mode captures as soon as the unit is enabled.
// (RULE_10) Synchronous mode: each selected sync event clears the counter.
// (RULE_11) Trigger mode holds the counter until the trigger event arrives.
// (RULE_12) Selector zero with trigger select clear means free-running.
// (RULE_13) A nonzero selector means synchronous or trigger mode.
// (RULE_14) With nonzero selector, trigger select chooses trigger over sync.
// (RULE_15) The selector value picks the sync or trigger source.
// (RULE_16) Selector zero with trigger select set means software trigger.
// (RULE_17) Software trigger mode starts capturing when software sets status.
// (RULE_18) Each unit raises an interrupt after a chosen number of captures.
// (RULE_19) Reset empties the store, zeroes counters, selects free-running; here reset leaves the mode to the select inputs.
// (RULE_20) A full store refuses captures and raises a sticky overflow flag.
`timescale 1ns/1ps
`default_nettype none
module icap_top (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Capture pins and external clock sources, asynchronous
  input  wire logic [icap_pkg::UNITS-1:0]    capture_input_pin,
  input  wire logic [icap_pkg::EXT_CLKS-1:0] ext_clock_source,
  // Internal sync and trigger events, one-cycle pulses on clk_sys
  input  wire logic [icap_pkg::SYNC_SRCS-1:0] sync_event,
  // Per-unit configuration
  input  wire logic [icap_pkg::UNITS-1:0] unit_enable,
  input  wire logic [icap_pkg::UNITS-1:0][icap_pkg::CLK_SEL_W-1:0]
                                          clock_select,
  input  wire logic [icap_pkg::UNITS-1:0][icap_pkg::SEL_W-1:0]
                                          sync_source_select,
  input  wire logic [icap_pkg::UNITS-1:0] trigger_mode_select,
  input  wire logic [icap_pkg::UNITS-1:0][icap_pkg::IRQ_SEL_W-1:0]
                                          irq_capture_count,
  input  wire logic [icap_pkg::PAIRS-1:0] cascade_enable,
  // Software strobes, one-cycle pulses
  input  wire logic [icap_pkg::UNITS-1:0] trigger_set,
  input  wire logic [icap_pkg::UNITS-1:0] trigger_clear,
  input  wire logic [icap_pkg::UNITS-1:0] capture_read,
  input  wire logic [icap_pkg::UNITS-1:0] overflow_clear,
  // Status and data
  output logic [icap_pkg::UNITS-1:0] trigger_run_status,
  output logic [icap_pkg::UNITS-1:0][icap_pkg::CNT_W-1:0] capture_counter,
  output logic [icap_pkg::UNITS-1:0][icap_pkg::CNT_W-1:0] capture_value,
  output logic [icap_pkg::UNITS-1:0] capture_valid,
  output logic [icap_pkg::UNITS-1:0] capture_full,
  output logic [icap_pkg::UNITS-1:0] capture_overflow,
  output logic [icap_pkg::UNITS-1:0] capture_irq
);

  // Mode from selector and trigger select bit
  function automatic icap_pkg::icap_mode_e mode_of(
    input logic [icap_pkg::SEL_W-1:0] sel,
    input logic                       trig
  );
    if (sel == icap_pkg::SYNC_NONE) begin
      mode_of = trig ? icap_pkg::ICAP_SW_TRIG : icap_pkg::ICAP_FREE;
    end else begin
      mode_of = trig ? icap_pkg::ICAP_HW_TRIG : icap_pkg::ICAP_SYNC;
    end
  endfunction

  // Selected internal event; codes above thirty select nothing
  function automatic logic pick_event(
    input logic [icap_pkg::SYNC_SRCS-1:0] ev,
    input logic [icap_pkg::SEL_W-1:0]     sel
  );
    if (sel == icap_pkg::SYNC_NONE || sel > icap_pkg::SYNC_LAST) begin
      pick_event = 1'b0;
    end else begin
      pick_event = ev[sel - icap_pkg::SYNC_LAST + 5'h1d];
    end
  endfunction

  // Selected counter tick; code zero is the system clock itself
  function automatic logic pick_tick(
    input logic [icap_pkg::EXT_CLKS-1:0]  edges,
    input logic [icap_pkg::CLK_SEL_W-1:0] sel
  );
    if (sel == icap_pkg::CLK_SYSTEM) begin
      pick_tick = 1'b1;
    end else if (sel > icap_pkg::CLK_LAST) begin
      pick_tick = 1'b0;
    end else begin
      pick_tick = edges[sel - icap_pkg::CLK_LAST + 3'h4];
    end
  endfunction

  logic                              rst_meta_n;
  logic                              rst_sys_n;
  logic [icap_pkg::UNITS-1:0]        pin_sync;
  logic [icap_pkg::UNITS-1:0]        pin_prev;
  logic [icap_pkg::EXT_CLKS-1:0]     clk_src_sync;
  logic [icap_pkg::EXT_CLKS-1:0]     clk_src_prev;
  logic [icap_pkg::UNITS-1:0][icap_pkg::CNT_W-1:0] count;
  logic [icap_pkg::UNITS-1:0][icap_pkg::IRQ_SEL_W-1:0] irq_tally;
  wire  [icap_pkg::UNITS-1:0][icap_pkg::CNT_W-1:0] fifo_head;
  wire  [icap_pkg::UNITS-1:0]        fifo_empty;
  wire  [icap_pkg::UNITS-1:0]        fifo_full;
  wire  [icap_pkg::UNITS-1:0]        fifo_refused;
  wire  [icap_pkg::EXT_CLKS-1:0]     clk_src_edge;
  wire  [icap_pkg::UNITS-1:0]        pin_rise;
  wire  [icap_pkg::UNITS-1:0]        own_tick;
  wire  [icap_pkg::UNITS-1:0]        own_clear;
  wire  [icap_pkg::UNITS-1:0]        own_run;
  wire  [icap_pkg::UNITS-1:0]        own_cap;
  wire  [icap_pkg::UNITS-1:0]        own_trig_ev;
  wire  [icap_pkg::UNITS-1:0]        is_trig;
  wire  [icap_pkg::UNITS-1:0]        eff_tick;
  wire  [icap_pkg::UNITS-1:0]        eff_clear;
  wire  [icap_pkg::UNITS-1:0]        eff_run;
  wire  [icap_pkg::UNITS-1:0]        eff_cap;
  wire  [icap_pkg::UNITS-1:0]        next_trig;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sys_n  <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sys_n  <= rst_meta_n;
    end
  end

  // Pins are asynchronous, so they pass two flops first
  icap_sync #(.W(icap_pkg::UNITS)) u_pin_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_sys_n),
    .async_in (capture_input_pin),
    .sync_out (pin_sync)
  );

  icap_sync #(.W(icap_pkg::EXT_CLKS)) u_clk_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_sys_n),
    .async_in (ext_clock_source),
    .sync_out (clk_src_sync)
  );

  // Edge history taken from the settled second stage only
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      pin_prev     <= '0;
      clk_src_prev <= '0;
    end else begin
      pin_prev     <= pin_sync;
      clk_src_prev <= clk_src_sync;
    end
  end

  // External sources tick on their rising edge; limits them to fsys/2
  assign clk_src_edge = clk_src_sync & ~clk_src_prev;
  assign pin_rise     = pin_sync & ~pin_prev;

  // (RULE_01) one independent unit per index
  genvar gi;
  generate
    for (gi = 0; gi < icap_pkg::UNITS; gi++) begin : g_unit
      icap_pkg::icap_mode_e mode;
      // (RULE_12) mode decode from selector
      // (RULE_13) nonzero selector picks sync or trigger
      // (RULE_14) trigger bit chooses trigger
      // (RULE_16) software trigger decode
      assign mode = mode_of(sync_source_select[gi],
                            trigger_mode_select[gi]);
      assign is_trig[gi] = (mode == icap_pkg::ICAP_HW_TRIG) ||
                           (mode == icap_pkg::ICAP_SW_TRIG);
      // (RULE_03) source from thirty events
      // (RULE_15) selector picks event
      assign own_trig_ev[gi] = (mode == icap_pkg::ICAP_HW_TRIG) &&
                               pick_event(sync_event,
                                          sync_source_select[gi]);
      // (RULE_10) sync event clears counter
      assign own_clear[gi] = (mode == icap_pkg::ICAP_SYNC) &&
                             pick_event(sync_event,
                                        sync_source_select[gi]);
      // (RULE_05) one of six clocks
      // (RULE_07) tick from selected source
      assign own_tick[gi] = pick_tick(clk_src_edge, clock_select[gi]);
      // (RULE_09) sync and free modes run on enable
      // (RULE_11) trigger modes wait for status
      // (RULE_17) software start via status bit
      assign own_run[gi] = unit_enable[gi] &&
                           (!is_trig[gi] || trigger_run_status[gi]);
      assign own_cap[gi] = own_run[gi] && pin_rise[gi];
      // Status set by the selected event or a software write
      assign next_trig[gi] = is_trig[gi] &&
                             (own_trig_ev[gi] || trigger_set[gi] ||
                              (trigger_run_status[gi] &&
                               !trigger_clear[gi]));

      // (RULE_02) odd unit slaves to its even partner
      if ((gi % 2) == 1) begin : g_odd
        wire casc;
        assign casc = cascade_enable[gi / 2];
        assign eff_tick[gi]  = casc ? (eff_tick[gi-1] &&
                                       count[gi-1] == icap_pkg::CNT_MAX)
                                    : own_tick[gi];
        assign eff_clear[gi] = casc ? eff_clear[gi-1] : own_clear[gi];
        assign eff_run[gi]   = casc ? eff_run[gi-1] : own_run[gi];
        assign eff_cap[gi]   = casc ? eff_cap[gi-1] : own_cap[gi];
      end else begin : g_even
        assign eff_tick[gi]  = own_tick[gi];
        assign eff_clear[gi] = own_clear[gi];
        assign eff_run[gi]   = own_run[gi];
        assign eff_cap[gi]   = own_cap[gi];
      end

      // (RULE_04) four-entry store per unit
      // (RULE_08) push present count
      icap_fifo u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_sys_n),
        .push      (eff_cap[gi]),
        .push_data (count[gi]),
        .pop       (capture_read[gi]),
        .head      (fifo_head[gi]),
        .empty     (fifo_empty[gi]),
        .full      (fifo_full[gi]),
        .refused   (fifo_refused[gi])
      );

      // Counter; a disabled unit sits at zero so it restarts cleanly
      // (RULE_06) natural wrap to zero
      // (RULE_19) reset to zero
      always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
          count[gi] <= icap_pkg::CNT_ZERO;
        end else if (!unit_enable[gi] || eff_clear[gi]) begin
          count[gi] <= icap_pkg::CNT_ZERO;
        end else if (eff_run[gi] && eff_tick[gi]) begin
          count[gi] <= count[gi] + icap_pkg::CNT_ONE;
        end
      end

      // Trigger status; a set in the clearing cycle wins
      always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
          trigger_run_status[gi] <= 1'b0;
        end else begin
          trigger_run_status[gi] <= next_trig[gi];
        end
      end

      // (RULE_20) sticky overflow, set beats clear
      always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
          capture_overflow[gi] <= 1'b0;
        end else if (fifo_refused[gi]) begin
          capture_overflow[gi] <= 1'b1;
        end else if (overflow_clear[gi]) begin
          capture_overflow[gi] <= 1'b0;
        end
      end

      // (RULE_18) interrupt on every (irq_capture_count + 1)-th capture
      always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
          irq_tally[gi]   <= icap_pkg::IRQ_CNT_0;
          capture_irq[gi] <= 1'b0;
        end else if (eff_cap[gi] &&
                     irq_tally[gi] == irq_capture_count[gi]) begin
          irq_tally[gi]   <= icap_pkg::IRQ_CNT_0;
          capture_irq[gi] <= 1'b1;
        end else begin
          irq_tally[gi]   <= eff_cap[gi]
                             ? irq_tally[gi] + icap_pkg::IRQ_CNT_ONE
                             : irq_tally[gi];
          capture_irq[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered views; they trail the store by one cycle
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      capture_counter <= '0;
      capture_value   <= '0;
      capture_valid   <= '0;
      capture_full    <= '0;
    end else begin
      capture_counter <= count;
      capture_value   <= fifo_head;
      capture_valid   <= ~fifo_empty;
      capture_full    <= fifo_full;
    end
  end

endmodule
`default_nettype wire

// *** tb/icap_top_sva.sv ***
// Port-level checks for the six-unit capture block
`timescale 1ns/1ps
`default_nettype none
module icap_checker (
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             rst_n,
  // Events and settings
  input wire logic [5:0]       capture_input_pin,
  input wire logic [29:0]      sync_event,
  input wire logic [5:0]       unit_enable,
  input wire logic [5:0][2:0]  clock_select,
  input wire logic [5:0][4:0]  sync_source_select,
  input wire logic [5:0]       trigger_mode_select,
  input wire logic [2:0]       cascade_enable,
  input wire logic [5:0]       trigger_set,
  input wire logic [5:0]       overflow_clear,
  // Results
  input wire logic [5:0]       trigger_run_status,
  input wire logic [5:0][15:0] capture_counter,
  input wire logic [5:0]       capture_valid,
  input wire logic [5:0]       capture_full,
  input wire logic [5:0]       capture_overflow,
  input wire logic [5:0]       capture_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic free5;
  logic trig3;
  logic sw4;
  logic hit2;
  // Mode decodes; paired units are excluded since they borrow settings
  assign free5 = unit_enable[5] && clock_select[5] == 3'h0 &&
                 sync_source_select[5] == 5'h00 &&
                 !trigger_mode_select[5] && !cascade_enable[2];
  assign trig3 = unit_enable[3] && sync_source_select[3] != 5'h00 &&
                 trigger_mode_select[3] && !cascade_enable[1];
  assign sw4   = sync_source_select[4] == 5'h00 && trigger_mode_select[4];
  // Selected sync source of unit 2 fires, code 31 means none
  assign hit2  = sync_source_select[2] != 5'h00 &&
                 sync_source_select[2] != 5'h1f && !trigger_mode_select[2] &&
                 sync_event[sync_source_select[2] - 5'h01];

  reset_quiet_a: assert property ($rose(rst_n) |-> capture_valid == '0 &&
    capture_overflow == '0 && trigger_run_status == '0)
    else $error("outputs not idle after reset");
  free_count_a: assert property (free5 [*6] |=> capture_counter[5] ==
    $past(capture_counter[5]) + 16'h0001) else $error("free count slipped");
  idle_zero_a: assert property ((!unit_enable[1]) [*3] |->
    capture_counter[1] == 16'h0000) else $error("idle counter not zero");
  sync_clear_a: assert property (hit2 && unit_enable[2] |->
    ##[1:2] capture_counter[2] == 16'h0000) else $error("sync kept count");
  trig_hold_a: assert property ((trig3 && !trigger_run_status[3]) [*3]
    |-> $stable(capture_counter[3])) else $error("counter ran untriggered");
  status_free_a: assert property ((!sw4 && sync_source_select[4] ==
    5'h00) [*2] |-> !trigger_run_status[4]) else $error("status in free");
  sw_start_a: assert property (sw4 && trigger_set[4] |=>
    trigger_run_status[4]) else $error("software start not seen");
  capture_lat_a: assert property ($rose(capture_input_pin[5]) && free5 &&
    !capture_full[5] |-> ##[3:5] capture_valid[5]) else $error("no capture");
  ovf_sticky_a: assert property (capture_overflow[0] &&
    !overflow_clear[0] |=> capture_overflow[0]) else $error("overflow lost");
  irq_pulse_a: assert property (capture_irq[0] |=> !capture_irq[0])
    else $error("interrupt held too long");

  // Main scenarios reached
  cover property (trigger_run_status[3]);
  cover property (capture_overflow[0]);
  cover property (capture_irq[0]);
endmodule
`default_nettype wire

// *** tb/icap_event_src.sv ***
// Far-side model: capture pins, external clocks and sync pulses
`timescale 1ns/1ps
`default_nettype none
module icap_event_src (
  // Clock
  input  wire logic        clk_sys,
  // Event lines toward the block
  output logic      [5:0]  capture_input_pin,
  output logic      [4:0]  ext_clock_source,
  output logic      [29:0] sync_event
);
  // Lines idle low between events
  initial begin
    capture_input_pin = '0;
    ext_clock_source  = '0;
    sync_event        = '0;
  end
  // Pin held 3 cycles each level, above the 2-cycle minimum
  task automatic pin_pulse(input int u);
    @(negedge clk_sys);
    capture_input_pin[u] = 1'b1;
    repeat (3) @(negedge clk_sys);
    capture_input_pin[u] = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // One external tick, slow enough for the two-flop synchroniser
  task automatic ext_tick(input int i);
    @(negedge clk_sys);
    ext_clock_source[i] = 1'b1;
    repeat (2) @(negedge clk_sys);
    ext_clock_source[i] = 1'b0;
    @(negedge clk_sys);
  endtask
  // Sync events are single-cycle pulses on the system clock
  task automatic sync_pulse(input int n);
    @(negedge clk_sys);
    sync_event[n] = 1'b1;
    @(negedge clk_sys);
    sync_event[n] = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/icap_top_bench.sv ***
// Self-checking bench for the six-unit capture block
`timescale 1ns/1ps
`default_nettype none
module icap_top_bench;
  logic             clk_sys = 1'b0;
  logic             rst_n = 1'b0;
  wire logic [5:0]  pin;
  wire logic [4:0]  ext;
  wire logic [29:0] sev;
  logic [5:0]       en = '0, trg = '0, tset = '0, tclr = '0, rd = '0;
  logic [5:0]       oclr = '0;
  logic [5:0][2:0]  csel = '0;
  logic [5:0][4:0]  ssel = '0;
  logic [5:0][1:0]  icnt = '0;
  logic [2:0]       casc = '0;
  logic [5:0]       st, vld, full, ovf, irq;
  logic [5:0][15:0] cnt, val;
  logic [15:0]      c;
  int               errors = 0, checked = 0, irqs = 0;

  always #20 clk_sys = ~clk_sys;

  icap_event_src src_u (.clk_sys(clk_sys), .capture_input_pin(pin),
    .ext_clock_source(ext), .sync_event(sev));
  icap_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .capture_input_pin(pin), .ext_clock_source(ext), .sync_event(sev),
    .unit_enable(en), .clock_select(csel), .sync_source_select(ssel),
    .trigger_mode_select(trg), .irq_capture_count(icnt),
    .cascade_enable(casc), .trigger_set(tset), .trigger_clear(tclr),
    .capture_read(rd), .overflow_clear(oclr), .trigger_run_status(st),
    .capture_counter(cnt), .capture_value(val), .capture_valid(vld),
    .capture_full(full), .capture_overflow(ovf), .capture_irq(irq));

  // Interrupt pulses of unit 0 are tallied for the fill test
  always @(negedge clk_sys) if (irq[0] === 1'b1) irqs++;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  // Software strobe: 0 read, 1 trigger set, 2 trigger clear, 3 overflow
  task automatic strobe(input int k, input int u);
    @(negedge clk_sys);
    case (k)
      0: rd[u] = 1'b1;
      1: tset[u] = 1'b1;
      2: tclr[u] = 1'b1;
      default: oclr[u] = 1'b1;
    endcase
    @(negedge clk_sys);
    {rd, tset, tclr, oclr} = '0;
  endtask
  task automatic give_verdict();
    $display("errors %0d, checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the long wrap wait
  initial begin
    #3200000;
    errors++;
    give_verdict();
  end

  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(3);
    check1(|{vld, ovf, st, irq}, 1'b0);
    check16(cnt[0], 16'h0000);
    en = '1;
    icnt[0] = 2'h3;
    cyc(4);
    // Five captures spaced 6 cycles: the fifth meets a full store
    repeat (5) src_u.pin_pulse(0);
    cyc(6);
    check1(full[0], 1'b1);
    check1(ovf[0], 1'b1);
    check16(16'(irqs), 16'h0001);
    c = val[0];
    for (int i = 0; i < 3; i++) begin
      strobe(0, 0);
      cyc(2);
      check16(val[0], c + 16'h0006);
      c = val[0];
    end
    strobe(0, 0);
    cyc(2);
    check1(vld[0], 1'b0);
    strobe(3, 0);
    cyc(2);
    check1(ovf[0], 1'b0);
    // Every sync code: a foreign event is ignored, the chosen one clears
    for (int n = 1; n <= 30; n++) begin
      ssel[2] = 5'(n);
      cyc(20);
      src_u.sync_pulse(n % 30);
      cyc(3);
      check1(cnt[2] > 16'h0010, 1'b1);
      src_u.sync_pulse(n - 1);
      cyc(3);
      check1(cnt[2] < 16'h0008, 1'b1);
    end
    // Code 31 selects no source: the last event line must not clear
    ssel[2] = 5'h1f;
    cyc(20);
    src_u.sync_pulse(29);
    cyc(3);
    check1(cnt[2] > 16'h0010, 1'b1);
    // Hardware trigger on unit 3 from sync code 5
    ssel[3] = 5'h05;
    trg[3] = 1'b1;
    cyc(5);
    c = cnt[3];
    cyc(10);
    check16(cnt[3], c);
    check1(st[3], 1'b0);
    src_u.sync_pulse(4);
    cyc(4);
    check1(st[3], 1'b1);
    c = cnt[3];
    cyc(10);
    check16(cnt[3], c + 16'h000a);
    strobe(2, 3);
    cyc(2);
    check1(st[3], 1'b0);
    // Software trigger on unit 4: no capture before the status is set
    trg[4] = 1'b1;
    cyc(3);
    src_u.pin_pulse(4);
    cyc(6);
    check1(vld[4], 1'b0);
    strobe(1, 4);
    cyc(2);
    check1(st[4], 1'b1);
    src_u.pin_pulse(4);
    cyc(6);
    check1(vld[4], 1'b1);
    strobe(0, 4);
    // A free-running unit captures its pin within the stated latency
    src_u.pin_pulse(5);
    cyc(6);
    check1(vld[5], 1'b1);
    // Each external source advances unit 1 only on its own ticks
    for (int s = 1; s <= 5; s++) begin
      csel[1] = 3'(s);
      cyc(4);
      c = cnt[1];
      cyc(8);
      check16(cnt[1], c);
      repeat (3) src_u.ext_tick(s - 1);
      cyc(3);
      check16(cnt[1], c + 16'h0003);
    end
    // Clock code 6 has no source behind it, so the counter stands
    csel[1] = 3'h6;
    cyc(4);
    c = cnt[1];
    repeat (2) src_u.ext_tick(0);
    cyc(3);
    check16(cnt[1], c);
    csel[1] = 3'h0;
    // Pair 0 cascaded from zero; the low half wraps once
    casc[0] = 1'b1;
    en[1:0] = 2'b00;
    cyc(2);
    en[1:0] = 2'b11;
    cyc(65636);
    check16(cnt[1], 16'h0001);
    src_u.pin_pulse(0);
    cyc(6);
    check1(vld[1], 1'b1);
    check16(val[1], 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire

bind icap_top icap_checker chk_u (.*);
